// ==== rtl/sensor_cfg_pkg.sv ====
// Purpose: shared constants for the main sensor configuration register and its host controller
// Assumes: one 8-bit device register, APB-facing host registers, 25 MHz clock
// Notes: field positions, reset values and host register map live here
// Functional notes
// - axis field: 00 off, 01 X, 10 Y, 11 Z
// - host ignores unselected axes during self-test
// - polarity bit 4: clear positive, set negative
// - wire bit 3: clear 4-wire, set 3-wire
// - wire bit ignored unless serial peripheral selected
// - 3-wire: data-in bidirectional, data-out high-impedance
// - power-on, brown-out, hibernate exit restore 4-wire
// - shorted data lines force 3-wire mode; here only with serial peripheral selected
// - range field selects 2/4/8/16 g sensitivity
// - active bit 0: standby or measuring
// - pin mode: active read-only, pin sets mode
// - host enables pin mode only while standby
// - host sets active only without pin mode
// - power-on or soft reset gives standby
// - host keeps traffic low during self-test
package sensor_cfg_pkg;
  localparam logic [7:0] CFG_ADDR = 8'h15;
  localparam int AXIS_HI = 6;
  localparam int AXIS_LO = 5;
  localparam int POL_BIT = 4;
  localparam int WIRE_BIT = 3;
  localparam int RANGE_HI = 2;
  localparam int RANGE_LO = 1;
  localparam int ACTIVE_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'h02;
  localparam logic [7:0] CFG_WMASK = 8'h7F;
  localparam logic [1:0] AXIS_OFF = 2'h0;
  localparam logic [1:0] AXIS_X = 2'h1;
  localparam logic [1:0] AXIS_Y = 2'h2;
  localparam logic [1:0] AXIS_Z = 2'h3;
  localparam logic [1:0] RANGE_2G = 2'h0;
  localparam logic [1:0] RANGE_4G = 2'h1;
  localparam logic [1:0] RANGE_8G = 2'h2;
  localparam logic [1:0] RANGE_16G = 2'h3;
  localparam logic [10:0] SENS_2G = 11'h400;
  localparam logic [10:0] SENS_4G = 11'h200;
  localparam logic [10:0] SENS_8G = 11'h100;
  localparam logic [10:0] SENS_16G = 11'h080;
  // host register byte addresses
  localparam logic [11:0] HOST_WDATA = 12'h000;
  localparam logic [11:0] HOST_CTRL = 12'h004;
  localparam logic [11:0] HOST_STATUS = 12'h008;
  localparam int CTRL_PIN_MODE = 0;
  localparam int CTRL_READ = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REFUSED = 1;
  localparam int STAT_PIN_MODE = 2;
  localparam int STAT_DATA_LO = 8;

  // one-hot axis under self-test, bit 0 = X
  function automatic logic [2:0] axis_onehot(input logic [1:0] sel);
    logic [2:0] r;
    r = 3'h0;
    unique case (sel)
      AXIS_X: r = 3'h1;
      AXIS_Y: r = 3'h2;
      AXIS_Z: r = 3'h4;
      default: r = 3'h0;
    endcase
    return r;
  endfunction
endpackage

// ==== rtl/sensor_cfg_if.sv ====
// Purpose: register access path and mode strap between host controller and sensor
// Assumes: both ends on clk_i; host drives requests, device answers
// Notes: read data is valid one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
interface sensor_cfg_if;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic pin_mode_control_enable;
  modport host (output wr_en, output rd_en, output addr, output wdata,
    output pin_mode_control_enable, input rdata, input rvalid);
  modport device (input wr_en, input rd_en, input addr, input wdata,
    input pin_mode_control_enable, output rdata, output rvalid);
endinterface
`default_nettype wire

// ==== rtl/sensor_main_config_one.sv ====
// Purpose: device end, holds the main configuration byte and derives modes
// Assumes: reset_i covers power-on and brown-out; pins are asynchronous
// Notes: bit 7 soft reset is not kept here and reads zero
`timescale 1ns/1ps
`default_nettype none
module sensor_main_config_one (
  input wire logic clk_i,
  input wire logic reset_i,
  sensor_cfg_if.device bus,
  input wire logic soft_reset_i,
  input wire logic hibernate_exit_i,
  input wire logic interface_select_pin_i,
  input wire logic second_interrupt_pin_i,
  input wire logic data_lines_shorted_i,
  output logic [2:0] selftest_axis_o,
  output logic selftest_polarity_o,
  output logic three_wire_o,
  output logic data_in_bidir_o,
  output logic data_out_oe_o,
  output logic [1:0] full_scale_range_o,
  output logic [10:0] sensitivity_o,
  output logic measuring_o
);
  import sensor_cfg_pkg::*;

  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic spi_sel;
  logic second_interrupt_pin_lvl;
  logic shorted;
  logic eff_active;
  logic wire3;
  logic hit;

  // pins cross into clk_i through two flops each
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {data_lines_shorted_i, second_interrupt_pin_i, interface_select_pin_i};
      sync2_q <= sync1_q;
    end
  end

  assign spi_sel = sync2_q[0];
  assign second_interrupt_pin_lvl = sync2_q[1];
  assign shorted = sync2_q[2];
  assign hit = bus.addr == CFG_ADDR;

  // next register value from a host write
  always_comb
  begin
    cfg_d = cfg_q;
    if (bus.wr_en && hit)
    begin
      cfg_d = bus.wdata & CFG_WMASK;
      if (bus.pin_mode_control_enable)
      begin
        cfg_d[ACTIVE_BIT] = cfg_q[ACTIVE_BIT];
      end
    end
    if (hibernate_exit_i)
    begin
      cfg_d[WIRE_BIT] = 1'b0;
    end
  end

  // reset wins: power-on, brown-out and soft reset all land in standby
  always_ff @(posedge clk_i)
  begin
    if (reset_i || soft_reset_i)
    begin
      cfg_q <= CFG_RESET;
    end
    else
    begin
      cfg_q <= cfg_d;
    end
  end

  // pin level replaces the stored bit while pin mode is on
  assign eff_active = bus.pin_mode_control_enable ? second_interrupt_pin_lvl : cfg_q[ACTIVE_BIT];
  // with the serial peripheral selected, strapped shorting forces 3-wire whatever the bit holds
  assign wire3 = spi_sel && (cfg_q[WIRE_BIT] || shorted);

  // derived mode outputs, registered
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      selftest_axis_o <= 3'h0;
      selftest_polarity_o <= 1'b0;
      three_wire_o <= 1'b0;
      data_in_bidir_o <= 1'b0;
      data_out_oe_o <= 1'b0;
      full_scale_range_o <= RANGE_4G;
      sensitivity_o <= SENS_4G;
      measuring_o <= 1'b0;
    end
    else
    begin
      selftest_axis_o <= axis_onehot(cfg_q[AXIS_HI:AXIS_LO]);
      selftest_polarity_o <= cfg_q[POL_BIT];
      three_wire_o <= wire3;
      data_in_bidir_o <= wire3;
      data_out_oe_o <= spi_sel && !wire3;
      full_scale_range_o <= cfg_q[RANGE_HI:RANGE_LO];
      unique case (cfg_q[RANGE_HI:RANGE_LO])
        RANGE_2G: sensitivity_o <= SENS_2G;
        RANGE_4G: sensitivity_o <= SENS_4G;
        RANGE_8G: sensitivity_o <= SENS_8G;
        RANGE_16G: sensitivity_o <= SENS_16G;
      endcase
      measuring_o <= eff_active;
    end
  end

  // read answer one cycle after the strobe; unmapped address reads zero
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      bus.rdata <= 8'h00;
      bus.rvalid <= 1'b0;
    end
    else
    begin
      bus.rvalid <= bus.rd_en;
      if (bus.rd_en)
      begin
        bus.rdata <= hit ? {cfg_q[7:1], eff_active} : 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/sensor_cfg_host.sv ====
// Purpose: host end, APB slave that turns software orders into register accesses
// Assumes: zero-wait APB, device answers reads one cycle after the strobe
// Notes: refused orders set a sticky flag cleared by writing one
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sensor_cfg_host (
  input wire logic clk_i,
  input wire logic reset_i,
  sensor_cfg_if.host dev,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  import sensor_cfg_pkg::*;

  logic wr;
  logic rd;
  logic busy_q;
  logic refused_q;
  logic pin_q;
  logic active_shadow_q;
  logic [7:0] rdbuf_q;
  logic wr_cfg;
  logic wr_ctrl;
  logic wr_stat;
  logic want_pin;
  logic bad_write;
  logic bad_pin;

  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && penable_i && !pwrite_i;
  assign wr_cfg = wr && paddr_i == HOST_WDATA;
  assign wr_ctrl = wr && paddr_i == HOST_CTRL;
  assign wr_stat = wr && paddr_i == HOST_STATUS;
  assign want_pin = pwdata_i[CTRL_PIN_MODE];
  // setting active under pin mode is refused outright
  assign bad_write = wr_cfg && pwdata_i[ACTIVE_BIT] && pin_q;
  // pin mode only from standby
  assign bad_pin = wr_ctrl && want_pin && !pin_q && active_shadow_q;

  // device strobes, one cycle each, never during a pending read
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      dev.wr_en <= 1'b0;
      dev.rd_en <= 1'b0;
      dev.addr <= CFG_ADDR;
      dev.wdata <= 8'h00;
    end
    else
    begin
      dev.wr_en <= wr_cfg && !bad_write && !busy_q;
      dev.rd_en <= wr_ctrl && pwdata_i[CTRL_READ] && !busy_q;
      dev.addr <= CFG_ADDR;
      if (wr_cfg)
      begin
        dev.wdata <= pwdata_i[7:0];
      end
    end
  end

  // shadow of the stored active bit, kept for the interlocks
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      active_shadow_q <= 1'b0;
    end
    else if (wr_cfg && !bad_write && !busy_q && !pin_q)
    begin
      active_shadow_q <= pwdata_i[ACTIVE_BIT];
    end
  end

  // pin mode request; clearing is always allowed
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pin_q <= 1'b0;
    end
    else if (wr_ctrl && !bad_pin)
    begin
      pin_q <= want_pin;
    end
  end
  assign dev.pin_mode_control_enable = pin_q;

  // busy covers the read round trip so traffic stays one order at a time
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      busy_q <= 1'b0;
      rdbuf_q <= 8'h00;
    end
    else
    begin
      if (dev.rvalid)
      begin
        busy_q <= 1'b0;
        rdbuf_q <= dev.rdata;
      end
      else if (dev.rd_en)
      begin
        busy_q <= 1'b1;
      end
    end
  end

  // sticky refusal, a new refusal beats the clear
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      refused_q <= 1'b0;
    end
    else if (bad_write || bad_pin || ((wr_cfg || wr_ctrl) && busy_q))
    begin
      refused_q <= 1'b1;
    end
    else if (wr_stat && pwdata_i[STAT_REFUSED])
    begin
      refused_q <= 1'b0;
    end
  end

  // read mux; unmapped addresses return zero
  always_comb
  begin
    prdata_o = 32'h0000_0000;
    if (rd)
    begin
      unique case (paddr_i)
        HOST_WDATA: prdata_o = {24'h000000, dev.wdata};
        HOST_CTRL: prdata_o = {31'h0000_0000, pin_q};
        HOST_STATUS: prdata_o = {16'h0000, rdbuf_q, 5'h00, pin_q, refused_q,
          busy_q || dev.rd_en};
        default: prdata_o = 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verification/sensor_cfg_sva.sv ====
// Purpose: checks on the path between host controller and sensor register
// Assumes: one clock, synchronous active-high reset
// Notes: keeps its own copy of the stored byte to judge read data
`timescale 1ns/1ps
`default_nettype none
module sensor_cfg_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic soft_reset_i,
  input wire logic hibernate_exit_i,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic pin_mode_control_enable
);
  logic [7:0] cfg_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // shadow byte; hibernate exit beats a write landing at the same edge
  always_ff @(posedge clk_i)
  begin
    if (reset_i || soft_reset_i)
      cfg_q <= 8'h02;
    else
      cfg_q <= (wr_en ? {1'b0, wdata[6:1], pin_mode_control_enable ? cfg_q[0] : wdata[0]}
        : cfg_q) & (hibernate_exit_i ? 8'hF7 : 8'hFF);
  end
  a_read_answer: assert property (rd_en |=> rvalid) else $error("read not answered");
  a_answer_cause: assert property (rvalid |-> $past(rd_en)) else $error("stray read answer");
  a_addr_fixed: assert property ((wr_en || rd_en) |-> addr == 8'h15) else $error("bad address");
  a_no_overlap: assert property (wr_en |-> !rd_en) else $error("write and read together");
  a_top_bit_zero: assert property (rvalid |-> !rdata[7]) else $error("bit 7 read as one");
  a_fields_read: assert property (rvalid |-> rdata[6:1] == cfg_q[6:1])
    else $error("field read mismatch");
  a_active_read: assert property (rvalid && !pin_mode_control_enable |-> rdata[0] == cfg_q[0])
    else $error("active bit read mismatch");
  a_pin_standby: assert property ($rose(pin_mode_control_enable) |-> !cfg_q[0])
    else $error("pin mode enabled while active");
  a_no_set_active: assert property (wr_en && pin_mode_control_enable |-> !wdata[0])
    else $error("active set in pin mode");
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Purpose: self-checking bench for host controller and sensor register together
// Assumes: APB master here, expectations noted in queues
// Notes: monitor compares status reads and output snapshots
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sensor_cfg_pkg::*;
  logic clk_i = 0, reset_i = 1, soft_reset_i = 0, hib = 0, ifsel = 0, pin = 0, shorted = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, snap = 0, pm = 0, refd = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0] axis;
  logic pol, three, bidir, oe, meas;
  logic [1:0] full_scale_range;
  logic [10:0] sens;
  logic [7:0] cfg = 8'h02, b;
  logic [20:0] oq[$];
  logic [15:0] rq[$];
  int errors = 0, n_compared = 0, seed = 72106, i;
  sensor_cfg_if cif();
  sensor_main_config_one i_sensor_main_config_one (.clk_i(clk_i), .reset_i(reset_i),
    .bus(cif.device), .soft_reset_i(soft_reset_i), .hibernate_exit_i(hib),
    .interface_select_pin_i(ifsel), .second_interrupt_pin_i(pin),
    .data_lines_shorted_i(shorted), .selftest_axis_o(axis), .selftest_polarity_o(pol),
    .three_wire_o(three), .data_in_bidir_o(bidir), .data_out_oe_o(oe),
    .full_scale_range_o(full_scale_range), .sensitivity_o(sens), .measuring_o(meas));
  sensor_cfg_host i_sensor_cfg_host (.clk_i(clk_i), .reset_i(reset_i), .dev(cif.host),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  sensor_cfg_sva i_sensor_cfg_sva (.clk_i(clk_i), .reset_i(reset_i),
    .soft_reset_i(soft_reset_i), .hibernate_exit_i(hib), .wr_en(cif.wr_en),
    .rd_en(cif.rd_en), .addr(cif.addr), .wdata(cif.wdata), .rdata(cif.rdata),
    .rvalid(cif.rvalid), .pin_mode_control_enable(cif.pin_mode_control_enable));
  always #20 clk_i = ~clk_i;
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task final_report;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one APB transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    psel <= 0; penable <= 0;
  endtask
  // expected outputs; 3-wire only counts with the serial peripheral pin high
  function logic [20:0] outs(input logic [7:0] c);
    logic tw;
    tw = ifsel & (c[3] | shorted);
    return {(c[6:5] == 2'h0) ? 3'h0 : 3'h1 << (c[6:5] - 2'h1), c[4], tw, tw, ifsel & !tw,
      c[2:1], 11'h400 >> c[2:1], pm ? pin : c[0]};
  endfunction
  task expect_outs;
    oq.push_back(outs(cfg));
    snap <= 1;
    @(posedge clk_i);
    snap <= 0;
  endtask
  task wr_cfg(input logic [7:0] v);
    apb(1, HOST_WDATA, {24'h0, v});
    if (pm && v[0]) refd = 1;
    else cfg = {1'b0, v[6:1], pm ? cfg[0] : v[0]};
    // one order at a time keeps bus traffic low while self-test runs
    repeat (5) @(posedge clk_i);
  endtask
  task ctrl(input logic m);
    apb(1, HOST_CTRL, {31'h0, m});
    if (m && cfg[0]) refd = 1;
    else pm = m;
    repeat (5) @(posedge clk_i);
  endtask
  task rd_cfg;
    apb(1, HOST_CTRL, {30'h0, 1'b1, pm});
    repeat (2) @(posedge clk_i);
    rq.push_back({cfg[7:1], pm ? pin : cfg[0], 5'h0, pm, refd, 1'b0});
    apb(0, HOST_STATUS, 32'h0);
  endtask
  // monitor: oldest note against what appears
  always @(posedge clk_i)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0)
      check(prdata[15:0] & 16'hFF07, rq.pop_front(), "status");
    if (snap)
      check({axis, pol, three, bidir, oe, full_scale_range, sens, meas}, oq.pop_front(), "outputs");
    // refusals are reported in status, never as a bus error
    if (psel && penable)
      check({pready, pslverr}, 2'b10, "apb answer");
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    final_report;
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    reset_i <= 0;
    expect_outs;
    rd_cfg;
    // every axis and range code, random other bits and pins; no axis data is judged
    for (i = 0; i < 16; i++)
    begin
      {ifsel, shorted} <= 2'($random(seed));
      b = 8'($random(seed));
      b[6:5] = i[1:0];
      b[2:1] = i[3:2];
      wr_cfg(b);
      expect_outs;
      rd_cfg;
    end
    wr_cfg(8'h20);
    ctrl(1);
    pin <= 1;
    repeat (5) @(posedge clk_i);
    expect_outs;
    wr_cfg(8'h01);
    wr_cfg(8'h54);
    rd_cfg;
    apb(1, HOST_STATUS, 32'h2);
    refd = 0;
    ctrl(0);
    pin <= 0;
    wr_cfg(8'h03);
    ctrl(1);
    rd_cfg;
    // hibernate exit, soft reset, then a second power-on reset
    wr_cfg(8'h0E);
    hib <= 1;
    @(posedge clk_i);
    hib <= 0;
    cfg[3] = 0;
    repeat (3) @(posedge clk_i);
    expect_outs;
    rd_cfg;
    soft_reset_i <= 1;
    @(posedge clk_i);
    soft_reset_i <= 0;
    cfg = 8'h02;
    repeat (3) @(posedge clk_i);
    expect_outs;
    rd_cfg;
    wr_cfg(8'h7B);
    reset_i <= 1;
    repeat (3) @(posedge clk_i);
    reset_i <= 0;
    cfg = 8'h02; pm = 0; refd = 0;
    repeat (4) @(posedge clk_i);
    expect_outs;
    rd_cfg;
    final_report;
  end
endmodule
`default_nettype wire
